// File: verilog/acs_pkg.sv
// Shared constants and carrier types of the conversion sequencer
package acs_pkg;
	// Register word offsets on the plain register port
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_TRIG = 4'h1;
	localparam logic [3:0] A_STAT = 4'h2;
	localparam logic [3:0] A_RES  = 4'h3;
	localparam logic [3:0] A_PREV = 4'h4;
	localparam logic [3:0] A_ACC  = 4'h5;
	localparam logic [3:0] A_ERR  = 4'h6;
	localparam logic [3:0] A_SETP = 4'h7;
	localparam logic [3:0] A_THR  = 4'h8;
	localparam logic [3:0] A_CHAN = 4'h9;
	localparam logic [3:0] A_IRQ  = 4'hA;
	localparam logic [3:0] A_CLK  = 4'hB;

	// Control register bit positions
	localparam int B_ON    = 0;
	localparam int B_GO    = 1;
	localparam int B_CONTINUOUS_SELECT  = 2;
	localparam int B_JUST  = 3;
	localparam int B_RCSEL = 4;
	localparam int B_PREVIOUS_SOURCE_SELECT  = 5;
	localparam int B_DOUBLE_SAMPLE_SELECT  = 6;

	// Status register bit positions
	localparam int S_DONE = 0;
	localparam int S_COMPUTATION_READY_FLAG = 1;
	localparam int S_THR  = 2;
	localparam int S_BUSY = 3;
	localparam int S_PEND = 4;
	localparam int S_PWR  = 5;

	// Interrupt enable bit positions
	localparam int I_CONV = 0;
	localparam int I_PERI = 1;
	localparam int I_GLOB = 2;

	// Trigger source codes
	localparam logic [4:0] TRG_CHAN_WR = 5'h1F;
	localparam logic [4:0] TRG_RES_RD  = 5'h1D;
	localparam logic [4:0] TRG_ERR_RD  = 5'h1C;
	localparam logic [4:0] TRG_PERI_LO = 5'h08;
	localparam logic [4:0] TRG_PERI_HI = 5'h17;

	// Timing and conversion constants
	localparam logic [2:0]  INSTR_CLKS = 3'h4;
	localparam logic [3:0]  IDX_TOP    = 4'hB;
	localparam logic [11:0] SAR_MSB    = 12'h800;
	localparam logic [15:0] RST_WORD   = 16'h0000;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV, ST_COMPUTATION_READY_FLAG} acs_state_e;

	typedef struct packed {
		logic start;
		logic abort;
	} acs_sar_ctl_s;

	typedef struct packed {
		logic        done;
		logic [11:0] code;
	} acs_sar_res_s;

	typedef struct packed {
		logic [6:0] cnt;
		logic       tick;
	} acs_tad_st_s;

	typedef struct packed {
		logic         busy;
		logic [3:0]   idx;
		logic [11:0]  code;
		logic         last;
		logic [11:0]  dac;
		acs_sar_res_s res;
	} acs_sar_st_s;

	typedef struct packed {
		acs_state_e   st;
		logic         on;
		logic         go;
		logic         continuous_select;
		logic         just;
		logic         rcsel;
		logic         previous_source_select;
		logic         double_sample_select;
		logic [4:0]   src;
		logic [5:0]   div;
		logic         conv_ie;
		logic         peri_ie;
		logic         glob_ie;
		logic         done_f;
		logic         computation_ready_flag_f;
		logic         thr_f;
		logic [11:0]  res;
		logic [11:0]  prev;
		logic [11:0]  last;
		logic [15:0]  acc;
		logic [15:0]  err;
		logic [15:0]  setp;
		logic [15:0]  thr;
		logic [5:0]   chan;
		logic         pend;
		logic         pwr;
		logic         second;
		logic         trig_prev;
		logic [2:0]   wcnt;
		logic [15:0]  rdata;
		logic         wake_i;
		logic         wake_v;
		acs_sar_ctl_s sar;
	} acs_seq_st_s;

	localparam acs_seq_st_s SEQ_RST = '0;
	localparam acs_tad_st_s TAD_RST = '0;
	localparam acs_sar_st_s SAR_RST = '0;
endpackage : acs_pkg

// File: verilog/acs_tad_gen.sv
// Bit-period tick generator: divided system clock or RC strobe
`timescale 1ns/10ps
module acs_tad_gen (
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_run,
	input  wire logic       i_rc_sel,
	input  wire logic       i_rc_tick,
	input  wire logic [5:0] i_div,
	output logic            o_tick
);
	acs_pkg::acs_tad_st_s s_q;
	acs_pkg::acs_tad_st_s s_d;

	// Period is 2*(div+1) clocks; counter parks at zero while idle
	always_comb
	begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!i_run)
		begin
			s_d.cnt = 7'h00;
		end
		else if (i_rc_sel)
		begin
			s_d.tick = i_rc_tick; // RC strobe is free running, no divider
		end
		else if (s_q.cnt == {i_div, 1'b1})
		begin
			s_d.cnt = 7'h00;
			s_d.tick = 1'b1;
		end
		else
		begin
			s_d.cnt = s_q.cnt + 7'h01;
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			s_q <= acs_pkg::TAD_RST;
		else
			s_q <= s_d;
	end

	assign o_tick = s_q.tick;
endmodule : acs_tad_gen

// File: verilog/acs_sar.sv
// Successive-approximation bit engine with abort fill
`timescale 1ns/10ps
module acs_sar (
	input  wire logic                  i_clk,
	input  wire logic                  i_nrst,
	input  wire acs_pkg::acs_sar_ctl_s i_ctl,
	input  wire logic                  i_tick,
	input  wire logic                  i_cmp,
	output acs_pkg::acs_sar_res_s      o_res,
	output logic [11:0]                o_dac_code
);
	acs_pkg::acs_sar_st_s s_q;
	acs_pkg::acs_sar_st_s s_d;

	// One bit per tick, MSB first; abort fills the rest with the last bit
	always_comb
	begin
		s_d = s_q;
		s_d.res.done = 1'b0;
		if (i_ctl.start)
		begin
			s_d.busy = 1'b1;
			s_d.idx = acs_pkg::IDX_TOP;
			s_d.code = 12'h000;
			s_d.last = 1'b0;
			s_d.dac = acs_pkg::SAR_MSB;
		end
		else if (s_q.busy && i_ctl.abort)
		begin
			for (int i = 0; i < 12; i++)
			begin
				if (4'(i) <= s_q.idx)
					s_d.code[i] = s_q.last;
			end
			s_d.busy = 1'b0;
			s_d.res.done = 1'b1;
			s_d.res.code = s_d.code;
		end
		else if (s_q.busy && i_tick)
		begin
			s_d.code[s_q.idx] = i_cmp;
			s_d.last = i_cmp;
			if (s_q.idx == 4'h0)
			begin
				s_d.busy = 1'b0;
				s_d.res.done = 1'b1;
				s_d.res.code = s_d.code;
				s_d.dac = s_d.code;
			end
			else
			begin
				s_d.idx = s_q.idx - 4'h1;
				s_d.dac = s_d.code | (12'h001 << (s_q.idx - 4'h1));
			end
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			s_q <= acs_pkg::SAR_RST;
		else
			s_q <= s_d;
	end

	assign o_res = s_q.res;
	assign o_dac_code = s_q.dac;
endmodule : acs_sar

// File: verilog/acs_sequencer.sv
// Conversion sequencer: registers, start sources, completion, sleep handling
// Behaviour
// - Sleep wake vectors only with all enables
// - Result shown left or right justified
// - Result writes stored right justified always
// - Converts only when on; three start sources
// - Old result copied to previous when selected
// - Completion clears go unless continuous, sets flags, accumulates
// - Error and threshold every one or two
// - Computation runs after conversion has finished
// - Clearing go aborts, fills, still computes
// - Reset turns off and cancels conversion
// - RC clock delays start one instruction
// - Sleep completion wakes or powers down
// - Sleep trigger with RC clock converts
// - Sleep trigger otherwise waits for wake
// - Selected source rising edge sets go
// - Software event trigger codes, reserved codes
// - Peripheral trigger codes map to inputs
// - Done flag always set, software clears
`timescale 1ns/10ps
module acs_sequencer (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic [3:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [15:0]      o_rdata,
	input  wire logic [15:0] i_periph_trig,
	input  wire logic        i_sleep,
	input  wire logic        i_rc_tick,
	input  wire logic        i_cmp,
	output logic [11:0]      o_dac_code,
	output logic             o_conv_power,
	output logic             o_done_flag,
	output logic             o_thr_flag,
	output logic             o_wake_inline,
	output logic             o_wake_vector
);
	acs_pkg::acs_seq_st_s  s_q;
	acs_pkg::acs_seq_st_s  s_d;
	acs_pkg::acs_sar_res_s sar_res;
	logic                  tad_tick;
	logic                  ev_chan_wr;
	logic                  ev_res_rd;
	logic                  ev_err_rd;
	logic                  trig_lvl;
	logic [15:0]           rd_mux;

	// Maps a trigger code to its source level; reserved codes read low
	function automatic logic acs_trig_pick(
		input logic [4:0]  code,
		input logic [15:0] peri,
		input logic        chw,
		input logic        rrd,
		input logic        erd
	);
		logic pick;
		pick = 1'b0;
		case (code)
			acs_pkg::TRG_CHAN_WR: pick = chw;
			acs_pkg::TRG_RES_RD:  pick = rrd;
			acs_pkg::TRG_ERR_RD:  pick = erd;
			default:
			begin
				if (code >= acs_pkg::TRG_PERI_LO && code <= acs_pkg::TRG_PERI_HI)
					pick = peri[4'(code - acs_pkg::TRG_PERI_LO)];
			end
		endcase
		return pick;
	endfunction : acs_trig_pick

	// Software access events that can serve as triggers
	assign ev_chan_wr = i_wr && (i_addr == acs_pkg::A_CHAN);
	assign ev_res_rd = i_rd && (i_addr == acs_pkg::A_RES);
	assign ev_err_rd = i_rd && (i_addr == acs_pkg::A_ERR);
	assign trig_lvl = acs_trig_pick(s_q.src, i_periph_trig, ev_chan_wr, ev_res_rd, ev_err_rd);

	// Read multiplexer over the current state
	always_comb
	begin
		rd_mux = acs_pkg::RST_WORD;
		case (i_addr)
			acs_pkg::A_CTRL:
			begin
				rd_mux[acs_pkg::B_ON] = s_q.on;
				rd_mux[acs_pkg::B_GO] = s_q.go;
				rd_mux[acs_pkg::B_CONTINUOUS_SELECT] = s_q.continuous_select;
				rd_mux[acs_pkg::B_JUST] = s_q.just;
				rd_mux[acs_pkg::B_RCSEL] = s_q.rcsel;
				rd_mux[acs_pkg::B_PREVIOUS_SOURCE_SELECT] = s_q.previous_source_select;
				rd_mux[acs_pkg::B_DOUBLE_SAMPLE_SELECT] = s_q.double_sample_select;
			end
			acs_pkg::A_TRIG: rd_mux[4:0] = s_q.src;
			acs_pkg::A_STAT:
			begin
				rd_mux[acs_pkg::S_DONE] = s_q.done_f;
				rd_mux[acs_pkg::S_COMPUTATION_READY_FLAG] = s_q.computation_ready_flag_f;
				rd_mux[acs_pkg::S_THR] = s_q.thr_f;
				rd_mux[acs_pkg::S_BUSY] = (s_q.st != acs_pkg::ST_IDLE);
				rd_mux[acs_pkg::S_PEND] = s_q.pend;
				rd_mux[acs_pkg::S_PWR] = s_q.pwr;
			end
			// Left justified view shifts the stored right justified value
			acs_pkg::A_RES:  rd_mux = s_q.just ? {4'h0, s_q.res} : {s_q.res, 4'h0};
			acs_pkg::A_PREV: rd_mux = {4'h0, s_q.prev};
			acs_pkg::A_ACC:  rd_mux = s_q.acc;
			acs_pkg::A_ERR:  rd_mux = s_q.err;
			acs_pkg::A_SETP: rd_mux = s_q.setp;
			acs_pkg::A_THR:  rd_mux = s_q.thr;
			acs_pkg::A_CHAN: rd_mux[5:0] = s_q.chan;
			acs_pkg::A_IRQ:
			begin
				rd_mux[acs_pkg::I_CONV] = s_q.conv_ie;
				rd_mux[acs_pkg::I_PERI] = s_q.peri_ie;
				rd_mux[acs_pkg::I_GLOB] = s_q.glob_ie;
			end
			acs_pkg::A_CLK:  rd_mux[5:0] = s_q.div;
			default:         rd_mux = acs_pkg::RST_WORD;
		endcase
	end

	// Next-state logic: bus writes first, hardware sets afterwards so they win
	always_comb
	begin
		s_d = s_q;
		s_d.sar = '0;
		s_d.wake_i = 1'b0;
		s_d.wake_v = 1'b0;
		s_d.rdata = i_rd ? rd_mux : acs_pkg::RST_WORD;

		// Register writes
		if (i_wr)
		begin
			case (i_addr)
				acs_pkg::A_CTRL:
				begin
					s_d.on = i_wdata[acs_pkg::B_ON];
					s_d.go = i_wdata[acs_pkg::B_GO];
					s_d.continuous_select = i_wdata[acs_pkg::B_CONTINUOUS_SELECT];
					s_d.just = i_wdata[acs_pkg::B_JUST];
					s_d.rcsel = i_wdata[acs_pkg::B_RCSEL];
					s_d.previous_source_select = i_wdata[acs_pkg::B_PREVIOUS_SOURCE_SELECT];
					s_d.double_sample_select = i_wdata[acs_pkg::B_DOUBLE_SAMPLE_SELECT];
				end
				acs_pkg::A_TRIG: s_d.src = i_wdata[4:0];
				acs_pkg::A_STAT:
				begin
					// Write one to clear; only software clears these
					if (i_wdata[acs_pkg::S_DONE])
						s_d.done_f = 1'b0;
					if (i_wdata[acs_pkg::S_COMPUTATION_READY_FLAG])
						s_d.computation_ready_flag_f = 1'b0;
					if (i_wdata[acs_pkg::S_THR])
						s_d.thr_f = 1'b0;
				end
				acs_pkg::A_RES:  s_d.res = i_wdata[11:0];
				acs_pkg::A_ACC:  s_d.acc = i_wdata;
				acs_pkg::A_SETP: s_d.setp = i_wdata;
				acs_pkg::A_THR:  s_d.thr = i_wdata;
				acs_pkg::A_CHAN: s_d.chan = i_wdata[5:0];
				acs_pkg::A_IRQ:
				begin
					s_d.conv_ie = i_wdata[acs_pkg::I_CONV];
					s_d.peri_ie = i_wdata[acs_pkg::I_PERI];
					s_d.glob_ie = i_wdata[acs_pkg::I_GLOB];
				end
				acs_pkg::A_CLK:  s_d.div = i_wdata[5:0];
				default:         s_d.div = s_q.div;
			endcase
		end

		// Trigger edge; during sleep without the RC clock it is parked once
		s_d.trig_prev = trig_lvl;
		if (trig_lvl && !s_q.trig_prev && s_q.on)
		begin
			if (i_sleep && !s_q.rcsel)
				s_d.pend = 1'b1;
			else
				s_d.go = 1'b1;
		end
		if (!i_sleep && s_q.pend)
		begin
			s_d.pend = 1'b0;
			s_d.go = 1'b1;
		end

		// Sequencer
		case (s_q.st)
			acs_pkg::ST_IDLE:
			begin
				// Without the RC clock nothing starts while asleep
				if (s_q.on && s_q.go && (!i_sleep || s_q.rcsel))
				begin
					s_d.pwr = 1'b1;
					if (s_q.rcsel)
					begin
						s_d.st = acs_pkg::ST_DELAY;
						s_d.wcnt = acs_pkg::INSTR_CLKS - 3'h1;
					end
					else
					begin
						s_d.sar.start = 1'b1;
						s_d.st = acs_pkg::ST_CONV;
					end
				end
			end
			acs_pkg::ST_DELAY:
			begin
				// Hold off one instruction so the sleep can take effect first
				if (!s_d.on || !s_d.go)
					s_d.st = acs_pkg::ST_IDLE;
				else if (s_q.wcnt == 3'h0)
				begin
					s_d.sar.start = 1'b1;
					s_d.st = acs_pkg::ST_CONV;
				end
				else
					s_d.wcnt = s_q.wcnt - 3'h1;
			end
			acs_pkg::ST_CONV:
			begin
				if (!s_d.on)
				begin
					// Turning off cancels with no result
					s_d.sar.abort = 1'b1;
					s_d.st = acs_pkg::ST_IDLE;
				end
				else if (sar_res.done)
				begin
					if (s_q.previous_source_select)
						s_d.prev = s_q.res;
					s_d.res = sar_res.code;
					s_d.last = sar_res.code;
					if (!s_q.continuous_select)
						s_d.go = 1'b0;
					s_d.done_f = 1'b1;
					s_d.computation_ready_flag_f = 1'b1;
					s_d.acc = s_q.acc + {4'h0, sar_res.code};
					s_d.st = acs_pkg::ST_COMPUTATION_READY_FLAG;
				end
				else if (s_q.go && !s_d.go)
					s_d.sar.abort = 1'b1;
			end
			acs_pkg::ST_COMPUTATION_READY_FLAG:
			begin
				// Error and threshold follow the stored result by one cycle
				s_d.st = acs_pkg::ST_IDLE;
				s_d.second = s_q.double_sample_select ? !s_q.second : 1'b0;
				if (!s_q.double_sample_select || s_q.second)
				begin
					s_d.err = {4'h0, s_q.last} - s_q.setp;
					if ($signed(s_d.err) > $signed(s_q.thr))
						s_d.thr_f = 1'b1;
				end
				if (i_sleep)
				begin
					if (s_q.conv_ie && s_q.peri_ie)
					begin
						if (s_q.glob_ie)
							s_d.wake_v = 1'b1;
						else
							s_d.wake_i = 1'b1;
					end
					else
						s_d.pwr = 1'b0;
				end
			end
			default: s_d.st = acs_pkg::ST_IDLE;
		endcase

		// An off module holds nothing pending and draws no power
		if (!s_d.on)
		begin
			s_d.pwr = 1'b0;
			s_d.pend = 1'b0;
		end
	end

	// Whole state in one register; reset turns the module off
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			s_q <= acs_pkg::SEQ_RST;
		else
			s_q <= s_d;
	end

	// Bit-period tick source
	acs_tad_gen u_tad (
		.i_clk     (i_clk),
		.i_nrst    (i_nrst),
		.i_run     (s_q.st == acs_pkg::ST_CONV),
		.i_rc_sel  (s_q.rcsel),
		.i_rc_tick (i_rc_tick),
		.i_div     (s_q.div),
		.o_tick    (tad_tick)
	);

	// Bit decision engine
	acs_sar u_sar (
		.i_clk      (i_clk),
		.i_nrst     (i_nrst),
		.i_ctl      (s_q.sar),
		.i_tick     (tad_tick),
		.i_cmp      (i_cmp),
		.o_res      (sar_res),
		.o_dac_code (o_dac_code)
	);

	// Outputs straight from the state register
	assign o_rdata = s_q.rdata;
	assign o_conv_power = s_q.pwr;
	assign o_done_flag = s_q.done_f;
	assign o_thr_flag = s_q.thr_f;
	assign o_wake_inline = s_q.wake_i;
	assign o_wake_vector = s_q.wake_v;
endmodule : acs_sequencer

// File: tb/acs_sequencer_chk.sv
// Port assertions for the conversion sequencer
`timescale 1ns/10ps
module acs_sequencer_chk (
	input wire logic        i_clk,
	input wire logic        i_nrst,
	input wire logic [3:0]  i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        o_conv_power,
	input wire logic        o_done_flag,
	input wire logic        o_thr_flag,
	input wire logic        o_wake_inline,
	input wire logic        o_wake_vector
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	// Setpoint write, one idle cycle, then its read
	sequence s_setp_wr;
		i_wr && i_addr == acs_pkg::A_SETP;
	endsequence
	sequence s_setp_rd;
		i_rd && i_addr == acs_pkg::A_SETP;
	endsequence
	property p_setp_rb;
		s_setp_wr ##2 s_setp_rd |=> o_rdata == $past(i_wdata, 3);
	endproperty
	a_setp_rb: assert property (p_setp_rb)
		else $error("setpoint readback wrong");
	// Read data only stand in the cycle after a read strobe
	property p_rd_idle;
		!$past(i_rd) |-> o_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
	// Sticky flags drop only through a status clear write
	property p_done_clr;
		$fell(o_done_flag) |-> $past(i_wr && i_addr == acs_pkg::A_STAT && i_wdata[0]);
	endproperty
	a_done_clr: assert property (p_done_clr)
		else $error("done flag lost without clear");
	property p_thr_clr;
		$fell(o_thr_flag) |-> $past(i_wr && i_addr == acs_pkg::A_STAT && i_wdata[2]);
	endproperty
	a_thr_clr: assert property (p_thr_clr)
		else $error("threshold flag lost without clear");
	// Threshold result follows a finished conversion
	property p_thr_after;
		$rose(o_thr_flag) |-> $past(o_done_flag);
	endproperty
	a_thr_after: assert property (p_thr_after)
		else $error("threshold before conversion end");
	// Wake indications are single pulses, never both
	property p_wake_v;
		o_wake_vector |-> !o_wake_inline ##1 !o_wake_vector;
	endproperty
	a_wake_v: assert property (p_wake_v)
		else $error("vector wake not a lone pulse");
	property p_wake_i;
		o_wake_inline |=> !o_wake_inline;
	endproperty
	a_wake_i: assert property (p_wake_i)
		else $error("inline wake not a pulse");
	// Out of reset the block is off and quiet
	property p_rst;
		$rose(i_nrst) |-> !o_conv_power && !o_done_flag && !o_thr_flag;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs active after reset");
endmodule : acs_sequencer_chk

bind acs_sequencer acs_sequencer_chk acs_sequencer_chk_inst (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_conv_power(o_conv_power),
	.o_done_flag(o_done_flag), .o_thr_flag(o_thr_flag),
	.o_wake_inline(o_wake_inline), .o_wake_vector(o_wake_vector)
);

// File: tb/test_adc_conversion_sequencer.sv
// Register-level testbench of the conversion sequencer
`timescale 1ns/10ps
module test_adc_conversion_sequencer;
	logic        i_clk, i_nrst, i_wr, i_rd, i_sleep, i_rc_tick, i_cmp;
	logic [3:0]  i_addr;
	logic [15:0] i_wdata, i_periph_trig, o_rdata, q;
	logic [11:0] o_dac_code, vin;
	logic        o_conv_power, o_done_flag, o_thr_flag, o_wake_inline, o_wake_vector;
	logic [1:0]  rc_cnt;
	logic [4:0]  codes [4];
	int          n_mismatch, samples_checked, n_wake, n_vec;

	acs_sequencer acs_sequencer_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_periph_trig(i_periph_trig), .i_sleep(i_sleep), .i_rc_tick(i_rc_tick),
		.i_cmp(i_cmp), .o_dac_code(o_dac_code), .o_conv_power(o_conv_power),
		.o_done_flag(o_done_flag), .o_thr_flag(o_thr_flag),
		.o_wake_inline(o_wake_inline), .o_wake_vector(o_wake_vector));

	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Analog input model and RC strobe every 4 clocks; comparator lags the DAC code by one clock
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			i_cmp <= 1'b0;
			rc_cnt <= 2'h0;
			i_rc_tick <= 1'b0;
			n_wake <= 0;
			n_vec <= 0;
		end
		else
		begin
			i_cmp <= vin >= o_dac_code;
			rc_cnt <= rc_cnt + 2'h1;
			i_rc_tick <= rc_cnt == 2'h3;
			if (o_wake_inline === 1'b1)
				n_wake <= n_wake + 1;
			if (o_wake_vector === 1'b1)
				n_vec <= n_vec + 1;
		end
	end

	task automatic print_verdict;
		$display("Checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	// Bus cycles; an idle edge after each strobe keeps back-to-back calls apart
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask : wr

	// Read data stand only in the cycle after the strobe, taken mid-cycle
	task automatic rd(input logic [3:0] a);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		q = o_rdata;
		@(posedge i_clk);
	endtask : rd

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("Error %0t: word %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk_word

	task automatic chk_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("Error %0t: flag %b expected %b", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk_flag

	// Bounded wait for the done flag, then room for the computation step
	task automatic wait_done;
		int n;
		n = 0;
		while (o_done_flag !== 1'b1 && n < 400)
		begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 400)
		begin
			$display("Error %0t: done flag timeout", $time);
			n_mismatch++;
		end
		repeat (3) @(posedge i_clk);
	endtask : wait_done

	// Watchdog sized well beyond the roughly one thousand cycles of the sequence
	initial
	begin
		#100000;
		n_mismatch++;
		print_verdict();
	end

	initial
	begin
		{i_nrst, i_wr, i_rd, i_sleep} = 4'h0;
		{i_addr, i_wdata, i_periph_trig, vin} = '0;
		{n_mismatch, samples_checked} = '0;
		codes = '{acs_pkg::TRG_PERI_LO, acs_pkg::TRG_PERI_HI, acs_pkg::TRG_CHAN_WR,
			acs_pkg::TRG_ERR_RD};
		repeat (4) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		rd(acs_pkg::A_CTRL);
		chk_word(q, 16'h0000);
		rd(4'hF);
		chk_word(q, 16'h0000);
		// Result writes land right justified whatever the format
		wr(acs_pkg::A_CTRL, 16'h0001);
		wr(acs_pkg::A_RES, 16'h0ABC);
		rd(acs_pkg::A_RES);
		chk_word(q, 16'hABC0);
		wr(acs_pkg::A_CTRL, 16'h0029);
		rd(acs_pkg::A_RES);
		chk_word(q, 16'h0ABC);
		wr(acs_pkg::A_CLK, 16'h0001);
		wr(acs_pkg::A_THR, 16'h0010);
		wr(acs_pkg::A_SETP, 16'h0040);
		rd(acs_pkg::A_SETP);
		chk_word(q, 16'h0040);
		// Full conversion with previous copy, flags and error
		vin <= 12'h100;
		wr(acs_pkg::A_CTRL, 16'h002B);
		wait_done();
		rd(acs_pkg::A_RES);
		chk_word(q, 16'h0100);
		rd(acs_pkg::A_PREV);
		chk_word(q, 16'h0ABC);
		rd(acs_pkg::A_ACC);
		chk_word(q, 16'h0100);
		rd(acs_pkg::A_CTRL);
		chk_word(q, 16'h0029);
		rd(acs_pkg::A_STAT);
		chk_word(q & 16'h0007, 16'h0007);
		rd(acs_pkg::A_ERR);
		chk_word(q, 16'h00C0);
		chk_flag(o_thr_flag, 1'b1);
		wr(acs_pkg::A_STAT, 16'h0007);
		chk_flag(o_done_flag, 1'b0);
		// Abort after a few bits; undecided bits copy the last one
		vin <= 12'hFFF;
		wr(acs_pkg::A_CTRL, 16'h002B);
		repeat (16) @(posedge i_clk);
		wr(acs_pkg::A_CTRL, 16'h0029);
		wait_done();
		rd(acs_pkg::A_RES);
		chk_word(q, 16'h0FFF);
		chk_flag(o_done_flag, 1'b1);
		wr(acs_pkg::A_STAT, 16'h0007);
		// Hardware start sources: two peripheral lines, a channel write, an error read
		for (int i = 0; i < 4; i++)
		begin
			vin <= 12'h300 + 12'(i);
			wr(acs_pkg::A_TRIG, {11'h000, codes[i]});
			if (i < 2)
				i_periph_trig <= (i == 0) ? 16'h0001 : 16'h8000;
			else if (i == 2)
				wr(acs_pkg::A_CHAN, 16'h0005);
			else
				rd(acs_pkg::A_ERR);
			wait_done();
			i_periph_trig <= 16'h0000;
			rd(acs_pkg::A_RES);
			chk_word(q, {4'h0, vin});
			wr(acs_pkg::A_STAT, 16'h0007);
		end
		// Reserved source code never starts a conversion
		wr(acs_pkg::A_TRIG, 16'h001E);
		wr(acs_pkg::A_CHAN, 16'h0005);
		rd(acs_pkg::A_CTRL);
		chk_word(q, 16'h0029);
		// Continuous with double sampling: go stays, error on every second result
		wr(acs_pkg::A_SETP, 16'h0200);
		vin <= 12'h200;
		wr(acs_pkg::A_CTRL, 16'h004F);
		wait_done();
		rd(acs_pkg::A_ERR);
		chk_word(q, 16'h02C3);
		rd(acs_pkg::A_CTRL);
		chk_word(q, 16'h004F);
		wr(acs_pkg::A_STAT, 16'h0007);
		wait_done();
		rd(acs_pkg::A_ERR);
		chk_word(q, 16'h0000);
		wr(acs_pkg::A_CTRL, 16'h0009);
		wait_done();
		wr(acs_pkg::A_STAT, 16'h0007);
		// Sleep on the divided clock: triggers held as one pending start
		wr(acs_pkg::A_TRIG, {11'h000, acs_pkg::TRG_PERI_LO});
		i_sleep <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			i_periph_trig <= 16'(i % 2 == 0);
			@(posedge i_clk);
		end
		repeat (100) @(posedge i_clk);
		chk_flag(o_done_flag, 1'b0);
		i_sleep <= 1'b0;
		wait_done();
		chk_flag(o_done_flag, 1'b1);
		wr(acs_pkg::A_STAT, 16'h0007);
		repeat (100) @(posedge i_clk);
		chk_flag(o_done_flag, 1'b0);
		// Sleep on the RC clock converts and wakes to inline code
		wr(acs_pkg::A_IRQ, 16'h0003);
		wr(acs_pkg::A_CTRL, 16'h0039);
		i_sleep <= 1'b1;
		i_periph_trig <= 16'h0001;
		wait_done();
		chk_flag(o_done_flag, 1'b1);
		chk_word(16'(n_wake), 16'h0001);
		chk_flag(o_conv_power, 1'b1);
		// All three enables vector instead; with none the converter powers down
		wr(acs_pkg::A_STAT, 16'h0007);
		wr(acs_pkg::A_IRQ, 16'h0007);
		i_periph_trig <= 16'h0000;
		@(posedge i_clk);
		i_periph_trig <= 16'h0001;
		wait_done();
		chk_word(16'(n_vec), 16'h0001);
		chk_word(16'(n_wake), 16'h0001);
		wr(acs_pkg::A_STAT, 16'h0007);
		wr(acs_pkg::A_IRQ, 16'h0000);
		i_periph_trig <= 16'h0000;
		@(posedge i_clk);
		i_periph_trig <= 16'h0001;
		wait_done();
		chk_flag(o_conv_power, 1'b0);
		rd(acs_pkg::A_CTRL);
		chk_word(q, 16'h0039);
		// Reset in mid-conversion turns the module off
		i_sleep <= 1'b0;
		wr(acs_pkg::A_CTRL, 16'h000B);
		repeat (10) @(posedge i_clk);
		chk_flag(o_conv_power, 1'b1);
		i_nrst <= 1'b0;
		@(posedge i_clk);
		chk_flag(o_conv_power, 1'b0);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		rd(acs_pkg::A_CTRL);
		chk_word(q, 16'h0000);
		print_verdict();
	end
endmodule : test_adc_conversion_sequencer
